// [hdl/tie_cfg.svh]
// Purpose: offsets, field positions, masks and reset values of the timer irq enable/status block
// Assumes: 32-bit APB, one aligned word per register
// Notes:   definitions only
`ifndef TIE_CFG_SVH
`define TIE_CFG_SVH

`define TIE_NUM_CH          5
`define TIE_ADDR_W          12
// register word offsets (byte addresses)
`define TIE_OFS_ENABLE_BASE 12'h000
`define TIE_OFS_STATUS_BASE 12'h020
`define TIE_OFS_STRIDE      12'h004
// enable register fields
`define TIE_EN_TRIG_BIT     7
`define TIE_EN_RSVD_BIT     6
`define TIE_EN_UDF_BIT      5
`define TIE_EN_OVF_BIT      4
`define TIE_EN_D_BIT        3
`define TIE_EN_C_BIT        2
`define TIE_EN_B_BIT        1
`define TIE_EN_A_BIT        0
// status register fields
`define TIE_ST_DIR_BIT      7
`define TIE_ST_ONE_BIT      6
`define TIE_ST_UDF_BIT      5
`define TIE_ST_OVF_BIT      4
`define TIE_ST_D_BIT        3
`define TIE_ST_C_BIT        2
`define TIE_ST_B_BIT        1
`define TIE_ST_A_BIT        0
// reset values
`define TIE_ENABLE_RESET    8'h40
`define TIE_STATUS_RESET    8'hC0
// writable enable bits: full layout (ch0,3,4) and reduced layout (ch1,2)
`define TIE_EN_MASK_FULL    8'h9F
`define TIE_EN_MASK_RED     8'hB3
// implemented flag bits per layout
`define TIE_FLAG_MASK_FULL  8'h1F
`define TIE_FLAG_MASK_RED   8'h33

`endif

// [hdl/tie_pkg.sv]
// Purpose: shared types of the timer irq enable/status block
// Assumes: five channels, byte-wide registers
// Notes:   numbers live in tie_cfg.svh
package tie_pkg;
  typedef logic [7:0]      tie_byte_t;  // one register byte
  typedef logic [4:0]      tie_chan_t;  // one bit per channel
  typedef logic [4:0][7:0] tie_bank_t;  // one byte per channel
endpackage

// [hdl/tie_reg_if.sv]
// Purpose: carries register strobes and readback between bus slave and core
// Assumes: single clock domain
// Notes:   strobes are one-cycle, valid at the completing bus edge
`timescale 1ns/1ps
`default_nettype none
interface tie_reg_if;
  import tie_pkg::*;
  tie_chan_t en_wr;  // enable register write strobes
  tie_chan_t st_wr;  // status register write strobes
  tie_byte_t wdata;  // write byte
  tie_bank_t en_rd;  // enable readback
  tie_bank_t st_rd;  // status readback
  modport slave (output en_wr, output st_wr, output wdata, input en_rd, input st_rd);
  modport core  (input en_wr, input st_wr, input wdata, output en_rd, output st_rd);
endinterface
`default_nettype wire

// [hdl/tie_apb.sv]
// Purpose: APB slave in front of the enable and status registers
// Assumes: APB3 signalling, one wait state on every access
// Notes:   unmapped addresses answer with pslverr, writes to them are dropped
`timescale 1ns/1ps
`include "tie_cfg.svh"
`default_nettype none
module tie_apb
  import tie_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [`TIE_ADDR_W-1:0]   paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  tie_reg_if.slave                      regs
);
  // word index and bank split of the address
  wire logic [2:0] word_idx  = paddr[4:2];
  wire logic       is_status = paddr[5];
  // mapped: first 64 bytes, aligned, index below channel count
  wire logic       mapped    = (paddr[`TIE_ADDR_W-1:6] == '0) && (paddr[1:0] == 2'h0)
                               && (word_idx < 3'(`TIE_NUM_CH));
  // access phase still waiting for its answer
  wire logic       acc_wait  = psel && penable && !pready;
  // completing edge of a mapped write
  wire logic       wr_go     = psel && penable && pready && pwrite && mapped;
  wire tie_chan_t  idx_hot   = tie_chan_t'(5'h01 << word_idx);
  // read mux over both banks
  wire tie_byte_t  rd_byte   = is_status ? regs.st_rd[word_idx] : regs.en_rd[word_idx];

  assign regs.en_wr = (wr_go && !is_status) ? idx_hot : 5'h00;
  assign regs.st_wr = (wr_go && is_status) ? idx_hot : 5'h00;
  assign regs.wdata = pwdata[7:0];

  // answer one cycle into the access phase, drop it right after
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= acc_wait;
      pslverr <= acc_wait && !mapped;
      // upper bits read as zero; unmapped reads return zero
      if (acc_wait) begin
        prdata <= (mapped && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      end
    end
  end
endmodule
`default_nettype wire

// [hdl/tie_top.sv]
// Purpose: per-channel interrupt enable and event status registers of a five-channel 16-bit timer
// Assumes: counter events arrive as one-cycle pulses synchronous to clk
// Notes:   rst is power-on; standby and manual_rst are synchronous levels
//
// Overview of operation
// R1: trigger enable passes match A as converter start
// R2: enable bit 6 is reserved, writes ignored
// R3: channels 1,2 underflow enable gates underflow request
// R4: underflow enable reads 0 on channels 0,3,4
// R5: overflow enable gates overflow request everywhere
// R6: D and C enables on channels 0,3,4 only
// R7: B and A enables gate requests everywhere
// R8: channels 1,2 use the reduced enable layout
// R9: one 8-bit status register per channel
// R10: status loads C0 on power-on and standby
// R11: manual reset keeps every status register
// R12: flags clear by writing 0, never set
// R13: direction flag shows count direction, resets up
// R14: channel 0 direction position always reads 1
// R15: status bit 6 always reads 1
// R16: channels 1,2 use the reduced status layout
// R17: enable registers load 40 on reset, standby
// R18: match flags set on compare or capture
// R19: overflow and underflow wraps set their flags
// R20: request is flag AND enable, held until cleared
`timescale 1ns/1ps
`include "tie_cfg.svh"
`default_nettype none
module tie_top
  import tie_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic                     rst,
  // synchronous power-saving and manual reset levels
  input  wire logic                     standby,
  input  wire logic                     manual_rst,
  // APB slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [`TIE_ADDR_W-1:0]   paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  // counter events, one bit per channel, one-cycle pulses
  input  wire tie_chan_t                match_a_evt,
  input  wire tie_chan_t                match_b_evt,
  input  wire tie_chan_t                match_c_evt,
  input  wire tie_chan_t                match_d_evt,
  input  wire tie_chan_t                overflow_evt,
  input  wire tie_chan_t                underflow_evt,
  // counter direction level, 1 = counting up
  input  wire tie_chan_t                count_up,
  // interrupt requests, levels
  output tie_chan_t                     match_a_irq,
  output tie_chan_t                     match_b_irq,
  output tie_chan_t                     match_c_irq,
  output tie_chan_t                     match_d_irq,
  output tie_chan_t                     overflow_irq,
  output tie_chan_t                     underflow_irq,
  // converter start request, one-cycle pulse
  output tie_chan_t                     convert_start
);

  // carrier between the bus slave and the register core
  tie_reg_if regs ();

  // bus slave: decode, read mux and answer flops
  tie_apb u_apb (
    .clk     (clk),
    .rst     (rst),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .regs    (regs)
  );

  // stored enable bytes, reserved positions held at their constant value
  tie_bank_t enable_q;
  // stored flag bytes, only bits 5..0 are real storage
  tie_bank_t flag_q;
  // next values per channel
  tie_bank_t next_enable;
  tie_bank_t next_flag;
  // request terms computed from the stored state
  tie_bank_t req_term;
  // raw event bits lined up with the status layout
  tie_bank_t evt_bits;
  // clear bits from a status write
  tie_bank_t clr_bits;

  // one generate loop builds every channel
  for (genvar ch = 0; ch < `TIE_NUM_CH; ch++) begin : g_ch

    // channels 1 and 2 are the up/down counters with the reduced layout
    localparam bit REDUCED = (ch == 1) || (ch == 2); // R8 R16
    // writable enable positions for this layout
    localparam tie_byte_t EN_MASK = REDUCED ? `TIE_EN_MASK_RED : `TIE_EN_MASK_FULL; // R2 R4 R6 R8
    // implemented flag positions for this layout
    localparam tie_byte_t FL_MASK = REDUCED ? `TIE_FLAG_MASK_RED : `TIE_FLAG_MASK_FULL; // R16

    // events in status bit order, masked to what this channel has
    assign evt_bits[ch] = {2'b00,
                           underflow_evt[ch],
                           overflow_evt[ch],
                           match_d_evt[ch],
                           match_c_evt[ch],
                           match_b_evt[ch],
                           match_a_evt[ch]} & FL_MASK; // R18 R19

    // a status write clears every implemented flag written as 0
    assign clr_bits[ch] = regs.st_wr[ch] ? (~regs.wdata & FL_MASK) : 8'h00; // R12

    // enable next value: only writable positions follow the bus,
    // bit 6 keeps its reset 1 and reserved bits keep their 0
    assign next_enable[ch] = regs.en_wr[ch]
                           ? ((regs.wdata & EN_MASK) | (enable_q[ch] & ~EN_MASK))
                           : enable_q[ch]; // R2 R4 R8

    // flag next value: set wins over a clear in the same cycle, so a
    // wrap arriving while software clears is never lost; writing 1
    // cannot set a flag because clr_bits only removes bits
    assign next_flag[ch] = (flag_q[ch] & ~clr_bits[ch]) | evt_bits[ch]; // R12 R18 R19

    // request = flag AND enable; bits line up position for position
    assign req_term[ch] = flag_q[ch] & enable_q[ch] & FL_MASK; // R20 R3 R5 R6 R7

    // enable registers: power-on, standby and manual reset all reload
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        enable_q[ch] <= `TIE_ENABLE_RESET; // R17
      end else if (standby || manual_rst) begin
        enable_q[ch] <= `TIE_ENABLE_RESET; // R17
      end else begin
        enable_q[ch] <= next_enable[ch];
      end
    end

    // flag storage: power-on and standby reload, manual reset does not
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        flag_q[ch] <= `TIE_STATUS_RESET & FL_MASK; // R10
      end else if (standby) begin
        flag_q[ch] <= `TIE_STATUS_RESET & FL_MASK; // R10
      end else begin
        // manual_rst deliberately absent here
        flag_q[ch] <= next_flag[ch]; // R11
      end
    end

    // interrupt request flops; one cycle behind the flag, held as a
    // level until either the flag or the enable is cleared
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        match_a_irq[ch]   <= 1'b0;
        match_b_irq[ch]   <= 1'b0;
        match_c_irq[ch]   <= 1'b0;
        match_d_irq[ch]   <= 1'b0;
        overflow_irq[ch]  <= 1'b0;
        underflow_irq[ch] <= 1'b0;
      end else begin
        match_a_irq[ch]   <= req_term[ch][`TIE_EN_A_BIT]; // R7 R20
        match_b_irq[ch]   <= req_term[ch][`TIE_EN_B_BIT]; // R7 R20
        match_c_irq[ch]   <= req_term[ch][`TIE_EN_C_BIT]; // R6 R20
        match_d_irq[ch]   <= req_term[ch][`TIE_EN_D_BIT]; // R6 R20
        overflow_irq[ch]  <= req_term[ch][`TIE_EN_OVF_BIT]; // R5 R20
        underflow_irq[ch] <= req_term[ch][`TIE_EN_UDF_BIT]; // R3 R20
      end
    end

    // converter start follows the match A event itself, not the flag,
    // so a still-set flag does not retrigger conversions every cycle
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        convert_start[ch] <= 1'b0;
      end else begin
        convert_start[ch] <= match_a_evt[ch] && enable_q[ch][`TIE_EN_TRIG_BIT]; // R1
      end
    end

    // enable readback is the stored byte as is
    assign regs.en_rd[ch] = enable_q[ch]; // R4 R8

    // status readback: direction in bit 7, constant 1 in bit 6, flags below
    if (ch == 0) begin : g_dir_fixed
      // the increment-only channel has no direction to show
      assign regs.st_rd[ch] = {1'b1, 1'b1, flag_q[ch][5:0]}; // R14 R15 R9
    end else begin : g_dir_live
      // live direction; counter logic holds it at 1 after reset
      assign regs.st_rd[ch] = {count_up[ch], 1'b1, flag_q[ch][5:0]}; // R13 R15 R9
    end
  end

endmodule
`default_nettype wire

// [sim/tie_checker.sv]
// Purpose: port-level assertions for tie_top
// Assumes: pready follows the first access cycle, irq lags flag and enable by one cycle
// Notes:   bound into every tie_top instance
`timescale 1ns/1ps
`include "tie_cfg.svh"
`default_nettype none
module tie_checker
  import tie_pkg::*;
(
  input wire logic                   clk,
  input wire logic                   rst,
  input wire logic                   standby,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [`TIE_ADDR_W-1:0] paddr,
  input wire logic [31:0]            prdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  input wire tie_chan_t              match_a_evt,
  input wire tie_chan_t              match_a_irq,
  input wire tie_chan_t              match_b_irq,
  input wire tie_chan_t              match_c_irq,
  input wire tie_chan_t              match_d_irq,
  input wire tie_chan_t              overflow_irq,
  input wire tie_chan_t              underflow_irq,
  input wire tie_chan_t              convert_start
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // word-aligned enable or status slot
  wire logic mapped = paddr[1:0] == 2'h0 && (paddr <= 12'h010 || (paddr >= 12'h020 && paddr <= 12'h030));
  // setup cycle followed by the first access cycle
  sequence s_setup;
    psel && !penable ##1 psel && penable && !pready;
  endsequence
  a_ready_two_cycles: assert property (s_setup |=> pready) else $error("pready late");
  a_ready_one_pulse: assert property (pready |=> !pready) else $error("pready held");
  a_err_unmapped: assert property (pready |-> pslverr == !mapped) else $error("pslverr decode wrong");
  a_bit6_reads_one: assert property (pready && !pwrite && mapped |-> prdata[6] && prdata[31:8] == 24'h0)
    else $error("bit 6 or upper read bits wrong");
  a_dir_ch0_one: assert property (pready && !pwrite && paddr == 12'h020 |-> prdata[7]) else $error("ch0 bit 7 low");
  a_trig_needs_match: assert property ((convert_start & ~$past(match_a_evt)) == 5'h00)
    else $error("convert start without match");
  a_rsvd_irq_quiet: assert property ((underflow_irq & 5'h19) == 5'h00 && ((match_c_irq | match_d_irq) & 5'h06) == 5'h00)
    else $error("request on reserved position");
  a_standby_no_irq: assert property (standby [*2] |=> {match_a_irq, match_b_irq, match_c_irq, match_d_irq,
    overflow_irq, underflow_irq} == 30'h0) else $error("request survives standby");
endmodule
bind tie_top tie_checker i_tie_checker (.clk(clk), .rst(rst), .standby(standby), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .match_a_evt(match_a_evt),
  .match_a_irq(match_a_irq), .match_b_irq(match_b_irq), .match_c_irq(match_c_irq), .match_d_irq(match_d_irq),
  .overflow_irq(overflow_irq), .underflow_irq(underflow_irq), .convert_start(convert_start));
`default_nettype wire

// [sim/testbench.sv]
// Purpose: self-checking bench for tie_top
// Assumes: APB master with one idle cycle between transfers
// Notes:   events are driven as one 30-bit vector, a..d, overflow, underflow
`timescale 1ns/1ps
`include "tie_cfg.svh"
`default_nettype none
module testbench
  import tie_pkg::*;
;
  logic        clk = 0, rst = 1, standby = 0, manual_rst = 0;
  logic        psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic [29:0] evts = '0;      // all six event vectors
  tie_chan_t   count_up = 5'h1F;
  tie_chan_t   ia, ib, ic, id, iov, iun, convert_start;
  logic [7:0]  rd;             // last read byte
  int          num_errors = 0, checks = 0, cyc = 0;
  tie_top i_tie_top (.clk(clk), .rst(rst), .standby(standby), .manual_rst(manual_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .match_a_evt(evts[29:25]), .match_b_evt(evts[24:20]), .match_c_evt(evts[19:15]),
    .match_d_evt(evts[14:10]), .overflow_evt(evts[9:5]), .underflow_evt(evts[4:0]), .count_up(count_up),
    .match_a_irq(ia), .match_b_irq(ib), .match_c_irq(ic), .match_d_irq(id), .overflow_irq(iov),
    .underflow_irq(iun), .convert_start(convert_start));
  always #2 clk = ~clk;
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc > 5000) begin
      num_errors++;
      final_report;
    end
  end
  task final_report;
    if (num_errors == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one transfer: setup, access held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, 24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata[7:0];
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(rd, e);
  endtask
  function automatic logic red(int c); // reduced layout channels
    return c == 1 || c == 2;
  endfunction
  task automatic evt(input logic [29:0] v);
    @(posedge clk);
    evts <= v;
    @(posedge clk);
    evts <= '0;
  endtask
  task t_reset_vals;
    for (int c = 0; c < 5; c++) begin
      rdc(12'(4 * c), 8'h40);
      rdc(12'h020 + 12'(4 * c), 8'hC0);
    end
    rdc(12'h040, 8'h00);
    chk(err, 1'b1);
  endtask
  task t_enable_map;
    for (int c = 0; c < 5; c++) begin
      apb(1'b1, 12'(4 * c), 8'hFF);
      rdc(12'(4 * c), red(c) ? 8'hF3 : 8'hDF);
    end
  endtask
  task t_events;
    evt('1);
    // start pulse stands only in the cycle after the event edge
    #1;
    chk(convert_start, 5'h1F);
    @(posedge clk);
    #1;
    chk({ia, ib, ic, id, iov, iun}, {5'h1F, 5'h1F, 5'h19, 5'h19, 5'h1F, 5'h06});
    for (int c = 0; c < 5; c++) begin
      rdc(12'h020 + 12'(4 * c), red(c) ? 8'hF3 : 8'hDF);
      apb(1'b1, 12'h020 + 12'(4 * c), 8'hFF);
      rdc(12'h020 + 12'(4 * c), red(c) ? 8'hF3 : 8'hDF);
      apb(1'b1, 12'h020 + 12'(4 * c), 8'hFE);
    end
    repeat (2) @(posedge clk);
    #1;
    chk({ia, ib}, {5'h00, 5'h1F});
    // manual reset: enables reload, flags stay
    @(posedge clk);
    manual_rst <= 1'b1;
    @(posedge clk);
    manual_rst <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk(ib, 5'h00);
    for (int c = 0; c < 5; c++) begin
      rdc(12'(4 * c), 8'h40);
      rdc(12'h020 + 12'(4 * c), red(c) ? 8'hF2 : 8'hDE);
    end
    evt('1);
    #1;
    chk(convert_start, 5'h00);
    // re-arm channel 0 so standby has live requests to drop
    apb(1'b1, 12'h000, 8'hFF);
    repeat (2) @(posedge clk);
    #1;
    chk(ia, 5'h01);
    @(posedge clk);
    standby <= 1'b1;
    repeat (2) @(posedge clk);
    standby <= 1'b0;
    for (int c = 0; c < 5; c++) rdc(12'h020 + 12'(4 * c), 8'hC0);
    rdc(12'h000, 8'h40);
  endtask
  // direction level follows count_up except on ch0
  task t_direction;
    @(posedge clk);
    count_up <= 5'h14;
    for (int c = 0; c < 5; c++) rdc(12'h020 + 12'(4 * c), (c == 0 || c >= 4 || c == 2) ? 8'hC0 : 8'h40);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset_vals;
    t_enable_map;
    t_events;
    t_direction;
    final_report;
  end
endmodule
`default_nettype wire
